// ===== core/otp_access_map.svh
`ifndef OTP_ACCESS_MAP_SVH
`define OTP_ACCESS_MAP_SVH
`define REG_FRAME 8'h00
`define REG_OTP_CMD 8'h04
`define REG_OTP_DATA 8'h08
`define REG_OTP_PROG 8'h0C
`define REG_STATUS 8'h10
`define REG_CTRL 8'h14
`define REG_SRAM_WR 8'h18
`define REG_CFG_RD 8'h1C
`define RES_SEL 2'b01
`define FRAME_PREFIX 2'b11
`define OTP_RD_PREFIX 3'b001
`define CFG0_ADDR 6'h00
`define RUN_ADDR 6'h14
`define CFG0_RST 24'h000000
`define CMP_BIT 0
`define ECC_LSB 1
`define ECC_MSB 2
`define ECC_CORRECTED 2'h0
`define FETCH_OTP_BIT 3
`define QUAD_BIT 4
`define IMG_BIT 5
`define ST_ACTIVE 0
`define ST_READY 1
`define ST_CMP_ERR 2
`define ST_LOCK 3
`define ST_RUN 4
`define ST_OTP_DONE 8
`define CTRL_PRESET_BIT 0
`define CTRL_ROUTE_BIT 1
`define OTP_ERASED 8'hFF
`define OTP_LOCKED_DATA 8'h00
`define LOCK_ADDR 13'h0FFE
`define LOCK_BIT 0
`define SINGLE_PROG_TOP 12'hFBF
`define QUAD_PROG_TOP 11'h7BF
`define OTP_BYTES 4096
`define DRAM_WORDS 48
`define DSP_WIDTH 48
`define RES_WORDS 16
`define DSP_CLK_MHZ 100
`define SYS_CLK_MHZ 125
`endif

// ===== core/otp_access_pkg.sv
package otp_access_pkg;
  typedef logic [7:0] otp_byte_t;
  typedef logic [47:0] dsp_word_t;
  typedef enum logic [1:0] {
    POR_ISSUE = 2'b00,
    POR_WAIT = 2'b01,
    POR_DONE = 2'b10
  } por_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic [23:0] cfg0;
    logic run;
    logic dsp_active;
    logic ready;
    logic cmp_err;
    logic lock;
    por_t por;
    logic otp_pend;
    logic otp_done;
    otp_byte_t otp_byte;
    logic route;
    logic irq_n;
    logic irq_alt;
    logic gpio_s1;
    logic gpio_s2;
    logic vpp_s1;
    logic vpp_s2;
    logic fetch_pend;
    logic fetch_otp;
    logic fetch_oob;
    otp_byte_t fetch_data;
  } state_t;
  typedef struct packed {
    otp_byte_t a_data;
    otp_byte_t b_data;
  } otp_rd_t;
endpackage

// ===== core/otp_port_if.sv
`timescale 1ns/1ps
interface otp_port_if;
  logic [12:0] a_addr;
  logic a_raw;
  logic [7:0] a_data;
  logic [11:0] b_addr;
  logic [7:0] b_data;
  logic prog_en;
  logic [11:0] prog_addr;
  logic [7:0] prog_data;
  modport ctrl (output a_addr, a_raw, b_addr, prog_en, prog_addr, prog_data,
    input a_data, b_data);
  modport mem (input a_addr, a_raw, b_addr, prog_en, prog_addr, prog_data,
    output a_data, b_data);
endinterface

// ===== core/otp_store.sv
`timescale 1ns/1ps
`include "otp_access_map.svh"
module otp_store (
  input wire logic clk_sys,
  input wire logic rstn,
  otp_port_if.mem port
);
  import otp_access_pkg::*;

  otp_byte_t data_mem [`OTP_BYTES];
  otp_byte_t ecc_mem [`OTP_BYTES];
  otp_rd_t q;
  otp_rd_t d;
  logic prog_q;
  logic [11:0] prog_addr_q;
  otp_byte_t prog_old_q;

  function automatic logic [3:0] check_bits(input otp_byte_t v);
    check_bits[0] = v[0] ^ v[1] ^ v[3] ^ v[4] ^ v[6];
    check_bits[1] = v[0] ^ v[2] ^ v[3] ^ v[5] ^ v[6];
    check_bits[2] = v[1] ^ v[2] ^ v[3] ^ v[7];
    check_bits[3] = v[4] ^ v[5] ^ v[6] ^ v[7];
  endfunction

  // Check nibble is stored relative to the erased pattern so blank bytes decode clean
  function automatic otp_byte_t correct(input otp_byte_t v, input otp_byte_t e);
    logic [3:0] syn;
    otp_byte_t r;
    syn = e[3:0] ^ check_bits(`OTP_ERASED) ^ check_bits(v);
    r = v;
    unique case (syn)
      4'h3: r[0] = ~v[0];
      4'h5: r[1] = ~v[1];
      4'h6: r[2] = ~v[2];
      4'h7: r[3] = ~v[3];
      4'h9: r[4] = ~v[4];
      4'hA: r[5] = ~v[5];
      4'hB: r[6] = ~v[6];
      4'hC: r[7] = ~v[7];
      default: r = v;
    endcase
    correct = r;
  endfunction

  // Blank array: every byte, data and correction half alike, starts as ones
  initial begin
    for (int i = 0; i < `OTP_BYTES; i++) begin
      data_mem[i] = `OTP_ERASED;
      ecc_mem[i] = `OTP_ERASED;
    end
  end

  always_comb begin
    d = q;
    if (port.a_addr[12]) begin
      d.a_data = ecc_mem[port.a_addr[11:0]];
    end else if (port.a_raw) begin
      d.a_data = data_mem[port.a_addr[11:0]];
    end else begin
      d.a_data = correct(data_mem[port.a_addr[11:0]], ecc_mem[port.a_addr[11:0]]);
    end
    d.b_data = correct(data_mem[port.b_addr], ecc_mem[port.b_addr]);
  end

  always_ff @(posedge clk_sys) begin
    q <= d;
    prog_q <= port.prog_en;
    prog_addr_q <= port.prog_addr;
    prog_old_q <= data_mem[port.prog_addr];
    if (port.prog_en) begin
      // Writes can only pull bits low; the stored check nibble follows the same law
      data_mem[port.prog_addr] <= data_mem[port.prog_addr] & port.prog_data;
      ecc_mem[port.prog_addr] <= ecc_mem[port.prog_addr] &
        {4'hF, check_bits(data_mem[port.prog_addr] & port.prog_data) ^
        check_bits(`OTP_ERASED)};
    end
  end

  assign port.a_data = q.a_data;
  assign port.b_data = q.b_data;

  prog_mono_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    prog_q |-> (data_mem[prog_addr_q] & ~prog_old_q) == 8'h00)
    else $error("programming raised a cleared OTP bit");
endmodule

// ===== core/dsp_otp_access.sv
`timescale 1ns/1ps
`include "otp_access_map.svh"
module dsp_otp_access #(
  parameter int DRAM_WORDS = `DRAM_WORDS,
  parameter int RES_WORDS = `RES_WORDS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic stop_req,
  input wire logic run_end,
  input wire logic gpio_wake,
  input wire logic vpp_otp,
  output logic dsp_clk_en,
  input wire logic fetch_req,
  input wire logic [11:0] fetch_addr,
  output otp_access_pkg::otp_byte_t fetch_data,
  input wire logic dram_we,
  input wire logic [5:0] dram_addr,
  input wire otp_access_pkg::dsp_word_t dram_wdata,
  output otp_access_pkg::dsp_word_t dram_rdata,
  input wire logic res_we,
  input wire logic [3:0] res_addr,
  input wire logic [23:0] res_wdata,
  input wire logic data_ready_evt,
  output logic data_ready_irq_pin_n,
  output logic gpio_irq_alt_pin,
  output logic run_bit
);
  import otp_access_pkg::*;

  state_t q;
  state_t d;
  otp_port_if otp ();
  otp_byte_t sram [`OTP_BYTES];
  otp_byte_t sram_q;
  dsp_word_t dram [DRAM_WORDS];
  dsp_word_t dram_q;
  logic [23:0] res_mem [RES_WORDS];
  logic sram_we;
  logic cmp_en;
  logic fetch_from_otp;
  logic quad;
  logic frame_ok;
  logic cmd_ok;
  logic [11:0] otp_fetch_addr;

  otp_store u_otp (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .port(otp)
  );

  assign cmp_en = q.cfg0[`CMP_BIT];
  assign fetch_from_otp = q.cfg0[`FETCH_OTP_BIT];
  assign quad = q.cfg0[`QUAD_BIT];
  assign frame_ok = reg_wr && reg_addr == `REG_FRAME &&
    reg_wdata[31:30] == `FRAME_PREFIX;
  assign cmd_ok = reg_wr && reg_addr == `REG_OTP_CMD &&
    reg_wdata[23:21] == `OTP_RD_PREFIX && q.por == POR_DONE;

  // Quad images fold the fetch into one 2 kB half picked by the image bit
  always_comb begin
    if (quad) begin
      otp_fetch_addr = {q.cfg0[`IMG_BIT], fetch_addr[10:0]};
    end else begin
      otp_fetch_addr = fetch_addr;
    end
  end

  always_comb begin
    d = q;
    sram_we = 1'b0;
    d.rdata = 32'h00000000;
    d.gpio_s1 = gpio_wake;
    d.gpio_s2 = q.gpio_s1;
    d.vpp_s1 = vpp_otp;
    d.vpp_s2 = q.vpp_s1;
    otp.a_addr = `LOCK_ADDR;
    otp.a_raw = q.cfg0[`ECC_MSB:`ECC_LSB] != `ECC_CORRECTED;
    otp.b_addr = fetch_from_otp ? otp_fetch_addr : fetch_addr;
    otp.prog_en = 1'b0;
    otp.prog_addr = reg_wdata[19:8];
    otp.prog_data = reg_wdata[7:0];

    // Lock bit is sampled once after every rstn reset, in POR_WAIT; it holds until the next reset
    unique case (q.por)
      POR_ISSUE: d.por = POR_WAIT;
      POR_WAIT: begin
        d.lock = ~otp.a_data[`LOCK_BIT];
        d.por = POR_DONE;
      end
      POR_DONE: d.por = POR_DONE;
    endcase

    if (q.otp_pend) begin
      d.otp_byte = q.lock ? `OTP_LOCKED_DATA : otp.a_data;
      d.otp_done = 1'b1;
      d.otp_pend = 1'b0;
    end

    if (frame_ok) begin
      if (reg_wdata[29:24] == `CFG0_ADDR) begin
        d.cfg0 = reg_wdata[23:0];
      end else if (reg_wdata[29:24] == `RUN_ADDR) begin
        d.run = reg_wdata[0];
      end
    end
    if (cmd_ok) begin
      otp.a_addr = reg_wdata[20:8];
      d.otp_pend = 1'b1;
      d.otp_done = 1'b0;
    end
    if (reg_wr && reg_addr == `REG_OTP_PROG && q.vpp_s2) begin
      otp.prog_en = 1'b1;
    end
    if (reg_wr && reg_addr == `REG_SRAM_WR) begin
      sram_we = 1'b1;
    end
    if (reg_wr && reg_addr == `REG_CTRL) begin
      d.route = reg_wdata[`CTRL_ROUTE_BIT];
      if (reg_wdata[`CTRL_PRESET_BIT]) begin
        d.dsp_active = 1'b1;
        d.ready = 1'b0;
        d.cmp_err = 1'b0;
      end
    end

    if (reg_rd) begin
      if (reg_addr[7:6] == `RES_SEL) begin
        d.rdata = {8'h00, res_mem[reg_addr[5:2]]};
        if (reg_addr[5:2] == 4'h0) begin
          d.ready = 1'b0;
        end
      end else if (reg_addr == `REG_OTP_DATA) begin
        d.rdata[7:0] = q.otp_byte;
        d.rdata[`ST_OTP_DONE] = q.otp_done;
      end else if (reg_addr == `REG_STATUS) begin
        d.rdata[`ST_ACTIVE] = q.dsp_active;
        d.rdata[`ST_READY] = q.ready;
        d.rdata[`ST_CMP_ERR] = q.cmp_err;
        d.rdata[`ST_LOCK] = q.lock;
        d.rdata[`ST_RUN] = q.run;
      end else if (reg_addr == `REG_CFG_RD) begin
        d.rdata = {7'h00, q.run, q.cfg0};
      end
    end

    // Wake beats stop in the same cycle so an event is never slept through
    if (q.dsp_active && stop_req) begin
      d.dsp_active = 1'b0;
    end
    if (q.gpio_s2 || run_end) begin
      d.dsp_active = 1'b1;
    end

    if (data_ready_evt) begin
      d.ready = 1'b1;
    end
    d.irq_n = ~(d.ready && !d.route);
    d.irq_alt = d.ready && d.route;

    d.fetch_pend = fetch_req && q.dsp_active;
    d.fetch_otp = fetch_from_otp;
    d.fetch_oob = fetch_from_otp &&
      (quad ? fetch_addr[10:0] > `QUAD_PROG_TOP : fetch_addr > `SINGLE_PROG_TOP);
    if (q.fetch_pend) begin
      if (q.fetch_oob) begin
        d.fetch_data = `OTP_ERASED;
      end else begin
        d.fetch_data = q.fetch_otp ? otp.b_data : sram_q;
      end
      // Monitor only makes sense while code runs from SRAM; it is skipped whenever fetch_otp is set
      if (!q.fetch_otp && cmp_en && sram_q != otp.b_data) begin
        d.cmp_err = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '{rdata: 32'h00000000, cfg0: `CFG0_RST, run: 1'b0, dsp_active: 1'b1,
        ready: 1'b0, cmp_err: 1'b0, lock: 1'b0, por: POR_ISSUE, otp_pend: 1'b0,
        otp_done: 1'b0, otp_byte: 8'h00, route: 1'b0, irq_n: 1'b1, irq_alt: 1'b0,
        gpio_s1: 1'b0, gpio_s2: 1'b0, vpp_s1: 1'b0, vpp_s2: 1'b0, fetch_pend: 1'b0,
        fetch_otp: 1'b0, fetch_oob: 1'b0, fetch_data: 8'h00};
    end else begin
      q <= d;
    end
  end

  // Memories carry no reset; program image and data RAM are loaded by their owners
  always_ff @(posedge clk_sys) begin
    if (sram_we) begin
      sram[reg_wdata[19:8]] <= reg_wdata[7:0];
    end
    sram_q <= sram[fetch_addr];
  end

  always_ff @(posedge clk_sys) begin
    if (dram_we && q.dsp_active && 32'(dram_addr) < DRAM_WORDS) begin
      dram[dram_addr] <= dram_wdata;
    end
    dram_q <= (32'(dram_addr) < DRAM_WORDS) ? dram[dram_addr] : 48'h000000000000;
  end

  always_ff @(posedge clk_sys) begin
    if (res_we) begin
      res_mem[res_addr] <= res_wdata;
    end
  end

  // Gate only; the 100 MHz processor clock itself lives outside this block
  assign dsp_clk_en = q.dsp_active;
  assign reg_rdata = q.rdata;
  assign fetch_data = q.fetch_data;
  assign dram_rdata = dram_q;
  assign data_ready_irq_pin_n = q.irq_n;
  assign gpio_irq_alt_pin = q.irq_alt;
  assign run_bit = q.run;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence otp_cmd_s;
    cmd_ok && !q.lock;
  endsequence
  sequence otp_answer_s;
    ##2 q.otp_done && q.otp_byte == $past(otp.a_data);
  endsequence

  halt_on_stop_a: assert property (
    q.dsp_active && stop_req && !q.gpio_s2 && !run_end |=> !dsp_clk_en)
    else $error("processor clock not halted after stop");
  wake_on_event_a: assert property (
    !q.dsp_active && (run_end || q.gpio_s2) |=> dsp_clk_en)
    else $error("processor did not wake on event");
  irq_route_a: assert property (
    data_ready_evt && !q.route && !(reg_wr && reg_addr == `REG_CTRL) |=> ##1
    !data_ready_irq_pin_n && !gpio_irq_alt_pin)
    else $error("data-ready not shown on interrupt pin");
  otp_read_seq_a: assert property (otp_cmd_s |-> otp_answer_s)
    else $error("OTP read answer missing or wrong");
  lock_stable_a: assert property (q.por == POR_DONE |=> $stable(q.lock))
    else $error("readout lock changed after power-on");
  run_frame_a: assert property (
    frame_ok && reg_wdata[29:24] == `RUN_ADDR |=> run_bit == $past(reg_wdata[0]))
    else $error("run bit frame not applied");
  cmp_flag_a: assert property (
    q.fetch_pend && !q.fetch_otp && cmp_en && sram_q != otp.b_data |=> q.cmp_err[*2])
    else $error("compare mismatch not flagged");
  fetch_src_a: assert property (
    q.fetch_pend && q.fetch_otp && !q.fetch_oob |=> fetch_data == $past(otp.b_data))
    else $error("OTP fetch returned wrong byte");

  sequence res0_read_s;
    reg_rd && reg_addr == {`RES_SEL, 6'h00} && !data_ready_evt;
  endsequence
  sequence irq_idle_s;
    !q.ready && data_ready_irq_pin_n && !gpio_irq_alt_pin;
  endsequence
  sequence quad_beyond_s;
    fetch_req && fetch_from_otp && quad && fetch_addr[10:0] > `QUAD_PROG_TOP;
  endsequence

  ready_clear_a: assert property (res0_read_s |=> irq_idle_s)
    else $error("data-ready not cleared by result read");

  res_read_a: assert property (
    reg_rd && reg_addr[7:6] == `RES_SEL |=>
    reg_rdata == {8'h00, $past(res_mem[reg_addr[5:2]])})
    else $error("result register read returned wrong word");

  fetch_blank_a: assert property (
    q.fetch_pend && q.fetch_oob |=> fetch_data == `OTP_ERASED)
    else $error("fetch beyond program area not blank");

  quad_top_a: assert property (quad_beyond_s |=> q.fetch_oob)
    else $error("quad image top not treated as beyond program area");

  cmd_refused_a: assert property (
    reg_wr && reg_addr == `REG_OTP_CMD && reg_wdata[23:21] != `OTP_RD_PREFIX |=>
    !q.otp_pend)
    else $error("OTP read taken without its prefix");

  frame_refused_a: assert property (
    reg_wr && reg_addr == `REG_FRAME && reg_wdata[31:30] != `FRAME_PREFIX |=>
    $stable(q.cfg0) && $stable(run_bit))
    else $error("frame without prefix changed a register");

  lock_data_a: assert property (
    q.otp_pend && q.lock |=> q.otp_done && q.otp_byte == `OTP_LOCKED_DATA)
    else $error("locked OTP read leaked data");

  dram_range_a: assert property (
    32'(dram_addr) >= DRAM_WORDS |=> dram_rdata == 48'h000000000000)
    else $error("data RAM read beyond last word not zero");

  prog_blocked_a: assert property ((!vpp_otp)[*3] |-> !q.vpp_s2)
    else $error("programming voltage seen while pin low");
endmodule

// ===== tb/host.sv
`timescale 1ns/1ps
module host (
  input wire logic clk_sys,
  input wire logic [31:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Gap cycle after each strobe keeps one driver per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic frame(input logic [5:0] a, input logic [23:0] d);
    wr(8'h00, {2'b11, a, d});
  endtask
  task automatic otp_rd(input logic [12:0] a, output logic [7:0] b);
    logic [31:0] d;
    wr(8'h04, {8'h00, 3'b001, a, 8'h00});
    repeat (2) @(posedge clk_sys);
    rd(8'h08, d);
    b = d[7:0];
  endtask
  // Front end stopped first, then correction mode forced to corrected
  task automatic readback_prep();
    frame(6'h14, 24'h0);
    frame(6'h00, 24'h0);
  endtask
endmodule

// ===== tb/dsp_otp_access_tb_top.sv
`timescale 1ns/1ps
module dsp_otp_access_tb_top;
  import otp_access_pkg::*;
  logic clk_sys, rstn, stop_req, run_end, gpio_wake, vpp_otp, dsp_clk_en;
  logic reg_wr, reg_rd, fetch_req, dram_we, res_we, data_ready_evt, run_bit;
  logic data_ready_irq_pin_n, gpio_irq_alt_pin;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [11:0] fetch_addr;
  logic [5:0] dram_addr;
  logic [3:0] res_addr;
  logic [23:0] res_wdata;
  otp_byte_t fetch_data;
  dsp_word_t dram_wdata, dram_rdata;
  int mismatches, num_checks;

  host host_i (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  dsp_otp_access dsp_otp_access_i (.clk_sys, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .stop_req, .run_end, .gpio_wake, .vpp_otp,
    .dsp_clk_en, .fetch_req, .fetch_addr, .fetch_data, .dram_we, .dram_addr,
    .dram_wdata, .dram_rdata, .res_we, .res_addr, .res_wdata, .data_ready_evt,
    .data_ready_irq_pin_n, .gpio_irq_alt_pin, .run_bit);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input string n, input logic [47:0] e, input logic [47:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic fetch(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge clk_sys);
    fetch_req <= 1'b0;
    @(posedge clk_sys);
    #1 check("fetch", e, fetch_data);
  endtask
  task automatic prog(input logic [11:0] a, input logic [7:0] d);
    host_i.wr(8'h0C, {12'h000, a, d});
  endtask

  task automatic t_frame();
    logic [31:0] d;
    host_i.wr(8'h00, {2'b10, 6'h14, 24'h000001});
    host_i.rd(8'h1C, d);
    check("cfg", 32'h0, d);
    host_i.frame(6'h00, 24'h000006);
    host_i.frame(6'h14, 24'h000001);
    host_i.rd(8'h1C, d);
    check("cfg", 32'h01000006, d);
    check("run_bit", 1'b1, run_bit);
    host_i.readback_prep();
    host_i.rd(8'h10, d);
    check("run_bit", 1'b0, run_bit);
    check("st_run", 1'b0, d[4]);
  endtask

  task automatic t_otp();
    logic [7:0] b;
    logic [31:0] d;
    host_i.otp_rd(13'h0005, b);
    check("erased", 8'hFF, b);
    host_i.otp_rd(13'h1FFF, b);
    check("ecc_blank", 8'hFF, b);
    prog(12'h005, 8'hA5);
    host_i.otp_rd(13'h0005, b);
    check("no_vpp", 8'hFF, b);
    vpp_otp <= 1'b1;
    tick(4);
    prog(12'h005, 8'hA5);
    prog(12'h7C0, 8'h00);
    prog(12'h006, 8'h0F);
    prog(12'h006, 8'hF0);
    vpp_otp <= 1'b0;
    tick(4);
    host_i.otp_rd(13'h0005, b);
    check("otp5", 8'hA5, b);
    host_i.wr(8'h04, {8'h00, 3'b010, 13'h1FFF, 8'h00});
    host_i.rd(8'h08, d);
    check("cmd_refused", 9'h1A5, d[8:0]);
    // Double-programmed byte has spoilt check bits, so read it raw
    host_i.frame(6'h00, 24'h000002);
    host_i.otp_rd(13'h0006, b);
    check("otp6", 8'h00, b);
    host_i.readback_prep();
    // Byte 6 left out: its spoilt check bits make the corrected value meaningless
    for (int i = 0; i < 960; i++) begin
      host_i.otp_rd(13'(i), b);
      if (i != 6) begin
        check("readback", (i == 5) ? 8'hA5 : 8'hFF, b);
      end
    end
  endtask

  task automatic t_fetch();
    logic [31:0] d;
    host_i.wr(8'h18, {12'h000, 12'h003, 8'h3C});
    fetch(12'h003, 8'h3C);
    host_i.rd(8'h10, d);
    check("cmp_err", 1'b0, d[2]);
    host_i.frame(6'h00, 24'h000001);
    fetch(12'h003, 8'h3C);
    host_i.rd(8'h10, d);
    check("cmp_err", 1'b1, d[2]);
    host_i.wr(8'h14, 32'h1);
    host_i.rd(8'h10, d);
    check("cmp_err", 1'b0, d[2]);
    host_i.frame(6'h00, 24'h000008);
    fetch(12'h005, 8'hA5);
    fetch(12'h7C0, 8'h00);
    host_i.frame(6'h00, 24'h000018);
    fetch(12'h7C0, 8'hFF);
    fetch(12'h005, 8'hA5);
    host_i.frame(6'h00, 24'h000038);
    fetch(12'h005, 8'hFF);
    host_i.frame(6'h00, 24'h0);
  endtask

  task automatic t_dsp();
    @(posedge clk_sys);
    stop_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    tick(1);
    #1 check("clk_en", 1'b0, dsp_clk_en);
    @(posedge clk_sys);
    run_end <= 1'b1;
    @(posedge clk_sys);
    run_end <= 1'b0;
    tick(1);
    #1 check("clk_en", 1'b1, dsp_clk_en);
    @(posedge clk_sys);
    stop_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    gpio_wake <= 1'b1;
    tick(5);
    #1 check("clk_en", 1'b1, dsp_clk_en);
    @(posedge clk_sys);
    gpio_wake <= 1'b0;
    dram_we <= 1'b1;
    dram_addr <= 6'd47;
    dram_wdata <= 48'hA5A5_0123_4567;
    @(posedge clk_sys);
    dram_addr <= 6'd48;
    @(posedge clk_sys);
    dram_we <= 1'b0;
    dram_addr <= 6'd47;
    #1 check("dram48", 48'h0, dram_rdata);
    tick(1);
    #1 check("dram47", 48'hA5A5_0123_4567, dram_rdata);
  endtask

  task automatic t_irq();
    logic [31:0] d;
    @(posedge clk_sys);
    data_ready_evt <= 1'b1;
    res_we <= 1'b1;
    res_wdata <= 24'h123456;
    @(posedge clk_sys);
    data_ready_evt <= 1'b0;
    res_we <= 1'b0;
    tick(2);
    #1 check("irq_n", 1'b0, data_ready_irq_pin_n);
    check("irq_alt", 1'b0, gpio_irq_alt_pin);
    host_i.wr(8'h14, 32'h2);
    tick(2);
    #1 check("irq_alt", 1'b1, gpio_irq_alt_pin);
    check("irq_n", 1'b1, data_ready_irq_pin_n);
    host_i.rd(8'h40, d);
    check("res0", 32'h00123456, d);
    tick(2);
    #1 check("irq_alt", 1'b0, gpio_irq_alt_pin);
  endtask

  task automatic t_lock();
    logic [31:0] d;
    logic [7:0] b;
    vpp_otp <= 1'b1;
    tick(4);
    prog(12'hFFE, 8'hFE);
    vpp_otp <= 1'b0;
    tick(4);
    host_i.otp_rd(13'h0005, b);
    check("pre_lock", 8'hA5, b);
    @(posedge clk_sys);
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(4);
    host_i.rd(8'h10, d);
    check("lock", 1'b1, d[3]);
    host_i.otp_rd(13'h0005, b);
    check("locked", 8'h00, b);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial begin
    rstn = 1'b0;
    {stop_req, run_end, gpio_wake, vpp_otp, fetch_req, dram_we} = 6'h00;
    {res_we, data_ready_evt} = 2'h0;
    fetch_addr = 12'h000;
    dram_addr = 6'h00;
    dram_wdata = 48'h0;
    res_addr = 4'h0;
    res_wdata = 24'h0;
    mismatches = 0;
    num_checks = 0;
    tick(7);
    #1 check("clk_en", 1'b1, dsp_clk_en);
    check("irq_n", 1'b1, data_ready_irq_pin_n);
    check("run_bit", 1'b0, run_bit);
    @(posedge clk_sys);
    rstn <= 1'b1;
    tick(4);
    t_frame();
    t_otp();
    t_fetch();
    t_dsp();
    t_irq();
    t_lock();
    stop_test();
  end
endmodule
